// >>> hdl/cbst_defines.vh
// How it works
// - snapshot low half is read-only
// - snapshot samples clock after sysref, lsb first
// - temperature result read-only in bits 10-0
// - bit 0 reads multiplier lock flag
// - writing 1 to calibration bit 0 starts calibration
// - version register is read-only 16 bits
`ifndef CBST_DEFINES_VH
`define CBST_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CBST_IDX_SNAP_LO 8'h1e
`define CBST_IDX_TEMP 8'h1f
`define CBST_IDX_VER 8'h20
`define CBST_IDX_TRIM_A 8'h24
`define CBST_IDX_LOCK 8'h25
`define CBST_IDX_TRIM_B 8'h27
`define CBST_IDX_TRIM_C 8'h28
`define CBST_IDX_TRIM_D 8'h29
`define CBST_IDX_TRIM_E 8'h2a
`define CBST_IDX_TRIM_F 8'h2b
`define CBST_IDX_TRIM_G 8'h2c
`define CBST_IDX_TRIM_H 8'h2d
`define CBST_IDX_TRIM_I 8'h36
`define CBST_IDX_BIAS 8'h37
`define CBST_IDX_TRIM_J 8'h4d
`define CBST_IDX_CTRL 8'h50
`define CBST_IDX_IRQ_STAT 8'h51
`define CBST_IDX_IRQ_CLR 8'h52
`define CBST_IDX_IRQ_EN 8'h53

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBST_RST_TRIM_A 16'h84a3
`define CBST_RST_TRIM_B 16'h78e1
`define CBST_RST_TRIM_C 16'h78e1
`define CBST_RST_TRIM_D 16'h78f3
`define CBST_RST_TRIM_E 16'h76f3
`define CBST_RST_TRIM_F 16'h7707
`define CBST_RST_TRIM_G 16'h7707
`define CBST_RST_TRIM_H 16'h2abf
`define CBST_RST_ZERO 16'h0000
`define CBST_RST_STEP 8'h01

// ----------------------------------------------------------------
// field layouts
// ----------------------------------------------------------------
`define CBST_TEMP_W 11
`define CBST_BIAS_W 6
`define CBST_TRIM_I_WMASK 16'h3fff
`define CBST_CTRL_CAL_BIT 0
`define CBST_CTRL_STEP_LSB 8
`define CBST_CTRL_STEP_MSB 15
`define CBST_IRQ_SNAP 0
`define CBST_IRQ_LOCK_UP 1
`define CBST_IRQ_LOCK_DN 2
`define CBST_IRQ_W 3

`endif

// >>> hdl/cbst_regs.v
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cbst_defines.vh"

module cbst_regs #(
  parameter SNAP_BITS = 16,
  parameter [15:0] VERSION_CODE = 16'h0a5c // arbitrary value
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // device status inputs
  input wire clock_input,
  input wire sysref_request_input,
  input wire [10:0] die_temperature_readback,
  input wire multiplier_lock_flag,
  // device control outputs
  output reg freq_cal_trigger,
  output wire cal_enable,
  output wire [5:0] bias_current_control,
  output wire [15:0] trim_word_a,
  output wire irq
);

  // ----------------------------------------------------------------
  // trim store
  // ----------------------------------------------------------------
  localparam NTRIM = 10;
  localparam [3:0] NO_SLOT = 4'ha;

  // maps a register index onto a trim slot, NTRIM when not a trim
  function [3:0] trim_slot;
    input [7:0] idx;
    begin
      case (idx)
        `CBST_IDX_TRIM_A: trim_slot = 4'h0;
        `CBST_IDX_TRIM_B: trim_slot = 4'h1;
        `CBST_IDX_TRIM_C: trim_slot = 4'h2;
        `CBST_IDX_TRIM_D: trim_slot = 4'h3;
        `CBST_IDX_TRIM_E: trim_slot = 4'h4;
        `CBST_IDX_TRIM_F: trim_slot = 4'h5;
        `CBST_IDX_TRIM_G: trim_slot = 4'h6;
        `CBST_IDX_TRIM_H: trim_slot = 4'h7;
        `CBST_IDX_TRIM_I: trim_slot = 4'h8;
        `CBST_IDX_TRIM_J: trim_slot = 4'h9;
        default: trim_slot = NO_SLOT;
      endcase
    end
  endfunction

  // reset value of each trim slot
  function [15:0] trim_reset;
    input integer slot;
    begin
      case (slot[3:0])
        4'h0: trim_reset = `CBST_RST_TRIM_A;
        4'h1: trim_reset = `CBST_RST_TRIM_B;
        4'h2: trim_reset = `CBST_RST_TRIM_C;
        4'h3: trim_reset = `CBST_RST_TRIM_D;
        4'h4: trim_reset = `CBST_RST_TRIM_E;
        4'h5: trim_reset = `CBST_RST_TRIM_F;
        4'h6: trim_reset = `CBST_RST_TRIM_G;
        4'h7: trim_reset = `CBST_RST_TRIM_H;
        default: trim_reset = `CBST_RST_ZERO;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite address and data phase
  // ----------------------------------------------------------------
  reg wr_pend_q;
  reg rd_pend_q;
  reg [7:0] idx_q;
  wire take;
  wire [3:0] wslot;
  wire [3:0] rslot;

  assign take = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;
  assign wslot = trim_slot(idx_q);
  assign rslot = trim_slot(idx_q);

  // reads take one wait state so an earlier write is always visible
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        // addresses with any of bits 31-10 set fold onto index zero, which reads zero
        idx_q <= haddr[9:2] & {8{haddr[31:10] == 22'h000000}};
      end
    end
  end

  wire wr_en;
  assign wr_en = wr_pend_q;

  // ----------------------------------------------------------------
  // software-written registers
  // ----------------------------------------------------------------
  wire [15:0] trim_w [0:NTRIM-1];
  reg [5:0] bias_q;
  reg cal_en_q;
  reg [7:0] step_q;
  reg [`CBST_IRQ_W-1:0] irq_en_q;

  genvar g;
  generate
    for (g = 0; g < NTRIM; g = g + 1) begin : g_trim
      // one register per slot, seen by the read mux through trim_w
      reg [15:0] word_q;
      wire hit;
      assign hit = wr_en && ({28'h0000000, wslot} == g);
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          word_q <= trim_reset(g);
        end else if (hit) begin
          if (g == 8) begin
            // top two bits of trim i stay read-only zero
            word_q <= hwdata[15:0] & `CBST_TRIM_I_WMASK;
          end else begin
            word_q <= hwdata[15:0];
          end
        end
      end
      assign trim_w[g] = word_q;
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bias_q <= 6'h00;
      cal_en_q <= 1'b0;
      step_q <= `CBST_RST_STEP;
      irq_en_q <= {`CBST_IRQ_W{1'b0}};
      freq_cal_trigger <= 1'b0;
    end else begin
      freq_cal_trigger <= 1'b0;
      if (wr_en && idx_q == `CBST_IDX_BIAS) begin
        // bits 15-6 are dropped and read back as zero
        bias_q <= hwdata[5:0];
      end
      if (wr_en && idx_q == `CBST_IDX_CTRL) begin
        cal_en_q <= hwdata[`CBST_CTRL_CAL_BIT];
        step_q <= hwdata[`CBST_CTRL_STEP_MSB:`CBST_CTRL_STEP_LSB];
        // each write with the bit set launches one calibration
        freq_cal_trigger <= hwdata[`CBST_CTRL_CAL_BIT];
      end
      if (wr_en && idx_q == `CBST_IDX_IRQ_EN) begin
        irq_en_q <= hwdata[`CBST_IRQ_W-1:0];
      end
    end
  end

  assign cal_enable = cal_en_q;
  assign bias_current_control = bias_q;
  assign trim_word_a = trim_w[0];

  // ----------------------------------------------------------------
  // snapshot capture
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] st_q;
  reg sysref_prev_q;
  reg [7:0] dly_q;
  reg [4:0] bit_q;
  reg [SNAP_BITS-1:0] shift_q;
  reg [SNAP_BITS-1:0] snap_q;
  reg snap_done;
  wire [7:0] step_eff;
  wire sysref_rise;

  // a zero step would wrap round and wait 256 clocks, so it runs as one
  assign step_eff = (step_q == 8'h00) ? 8'h01 : step_q;
  assign sysref_rise = sysref_request_input & ~sysref_prev_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= ST_IDLE;
      sysref_prev_q <= 1'b0;
      dly_q <= 8'h00;
      bit_q <= 5'h00;
      shift_q <= {SNAP_BITS{1'b0}};
      snap_q <= {SNAP_BITS{1'b0}};
      snap_done <= 1'b0;
    end else begin
      sysref_prev_q <= sysref_request_input;
      snap_done <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (sysref_rise) begin
            st_q <= ST_RUN;
            dly_q <= step_eff;
            bit_q <= 5'h00;
          end
        end
        ST_RUN: begin
          if (dly_q == 8'h01) begin
            // one clock sample per delay step, lsb first
            shift_q[bit_q[3:0]] <= clock_input;
            dly_q <= step_eff;
            if (bit_q == SNAP_BITS - 1) begin
              st_q <= ST_IDLE;
              // the last sample goes straight into the snapshot
              snap_q <= {clock_input, shift_q[SNAP_BITS-2:0]};
              snap_done <= 1'b1;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end else begin
            dly_q <= dly_q - 8'h01;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status capture and interrupts
  // ----------------------------------------------------------------
  reg lock_q;
  reg [10:0] temp_q;
  reg [`CBST_IRQ_W-1:0] irq_stat_q;
  wire [`CBST_IRQ_W-1:0] irq_set;
  wire [`CBST_IRQ_W-1:0] irq_clr;

  assign irq_set = {lock_q & ~multiplier_lock_flag,
                    ~lock_q & multiplier_lock_flag,
                    snap_done};
  assign irq_clr = (wr_en && idx_q == `CBST_IDX_IRQ_CLR) ?
                   hwdata[`CBST_IRQ_W-1:0] : {`CBST_IRQ_W{1'b0}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b0;
      temp_q <= 11'h000;
      irq_stat_q <= {`CBST_IRQ_W{1'b0}};
    end else begin
      lock_q <= multiplier_lock_flag;
      temp_q <= die_temperature_readback;
      // a new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // level output, high while an enabled event stays pending
  assign irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg [15:0] rd_d;

  always @* begin
    rd_d = 16'h0000;
    if (rslot != NO_SLOT) begin
      rd_d = trim_w[rslot];
    end else begin
      case (idx_q)
        `CBST_IDX_SNAP_LO: rd_d = snap_q[15:0];
        `CBST_IDX_TEMP: rd_d = {5'h00, temp_q};
        `CBST_IDX_VER: rd_d = VERSION_CODE;
        `CBST_IDX_LOCK: rd_d = {15'h0000, lock_q};
        `CBST_IDX_BIAS: rd_d = {10'h000, bias_q};
        `CBST_IDX_CTRL: rd_d = {step_q, 7'h00, cal_en_q};
        `CBST_IDX_IRQ_STAT: rd_d = {13'h0000, irq_stat_q};
        `CBST_IDX_IRQ_EN: rd_d = {13'h0000, irq_en_q};
        default: rd_d = 16'h0000;
      endcase
    end
  end

  // hrdata keeps the last read value until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata <= {16'h0000, rd_d};
    end
  end

endmodule

// >>> testbench/cbst_regs_props.sv
`timescale 1ns/1ps
module cbst_regs_props (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // control outputs
  input wire freq_cal_trigger,
  input wire cal_enable,
  input wire [5:0] bias_current_control,
  input wire [15:0] trim_word_a
);
  // ----------------------------------------------------------------
  // accepted transfers
  // ----------------------------------------------------------------
  wire acc = hsel & htrans[1] & hready;
  wire rd_acc = acc & !hwrite;
  wire wr_acc = acc & hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_data_s;
    !hreadyout ##1 hreadyout;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rd_wait_a: assert property (rd_acc |=> rd_data_s)
    else $error("read data phase not one wait state");
  wr_nowait_a: assert property (wr_acc |=> hreadyout)
    else $error("write data phase stalled");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_acc, 2))
    else $error("read data changed without a read");
  rdata_upper_a: assert property (hrdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  cal_pulse_a: assert property (freq_cal_trigger |=> !freq_cal_trigger)
    else $error("calibration trigger longer than one cycle");
  cal_cause_a: assert property (freq_cal_trigger |->
    cal_enable && $past(wr_acc, 2))
    else $error("calibration trigger without enabling write");
  bias_write_a: assert property ($changed(bias_current_control) |->
    $past(wr_acc, 2))
    else $error("bias control changed without a write");
  trim_write_a: assert property ($changed(trim_word_a) |->
    $past(wr_acc, 2))
    else $error("trim word changed without a write");
  rst_vals_a: assert property ($rose(hresetn) |-> trim_word_a == 16'h84a3
    && bias_current_control == 6'h00 && !cal_enable)
    else $error("wrong values after reset");
endmodule

bind cbst_regs cbst_regs_props cbst_regs_props_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .freq_cal_trigger(freq_cal_trigger), .cal_enable(cal_enable),
  .bias_current_control(bias_current_control), .trim_word_a(trim_word_a));

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "cbst_defines.vh"
module tb;
  localparam [15:0] VER = 16'h1b2d; // arbitrary value
  reg hclk, hresetn, hsel, hwrite, clock_input, sysref, lock;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, t;
  reg [10:0] temp;
  reg [15:0] pat, d;
  reg [15:0] wv[16];
  reg rd_p = 1'b0;
  wire hreadyout, hresp, freq_cal_trigger, cal_enable, irq;
  wire [31:0] hrdata;
  wire [5:0] bias_current_control;
  wire [15:0] trim_word_a;
  logic [15:0] exp_q[$];
  int failures, n_tests, i, m, eff;
  logic [7:0] idx_t[16] = '{8'h1e, 8'h1f, 8'h20, 8'h24, 8'h25, 8'h27,
    8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h36, 8'h37, 8'h4d, 8'h50};
  logic [15:0] rst_t[16] = '{16'h0000, 16'h0000, VER, 16'h84a3, 16'h0000,
    16'h78e1, 16'h78e1, 16'h78f3, 16'h76f3, 16'h7707, 16'h7707, 16'h2abf,
    16'h0000, 16'h0000, 16'h0000, 16'h0100};
  logic [7:0] st_t[3] = '{8'h00, 8'h01, 8'h03};
  logic [15:0] prog_t[6] = '{16'h7961, 16'h7963, 16'h7541, 16'h7741,
    16'h7741, 16'h7561};

  cbst_regs #(.VERSION_CODE(VER)) cbst_regs_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .clock_input(clock_input), .sysref_request_input(sysref),
    .die_temperature_readback(temp), .multiplier_lock_flag(lock),
    .freq_cal_trigger(freq_cal_trigger), .cal_enable(cal_enable),
    .bias_current_control(bias_current_control),
    .trim_word_a(trim_word_a), .irq(irq));

  initial begin
    hclk = 0;
    forever #25 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task results;
    failures += exp_q.size();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // waits for an edge with hready high, bounded
  task wt;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        results();
      end
      @(posedge hclk);
    end
  endtask
  task xf(input [7:0] idx, input w, input [15:0] v);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hwdata <= {16'h0000, v};
    wt();
  endtask
  task wr(input [7:0] idx, input [15:0] v);
    xf(idx, 1'b1, v);
  endtask
  task rd(input [7:0] idx, input [15:0] v);
    exp_q.push_back(v);
    xf(idx, 1'b0, 16'h0000);
  endtask
  // read data monitor: oldest note against each completed read
  always @(posedge hclk) begin
    if (rd_p && hreadyout) chk(hrdata, {16'h0000, exp_q.pop_front()});
    if (hreadyout) rd_p <= hsel & htrans[1] & !hwrite & hresetn;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, clock_input, sysref, lock} = 6'h00;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    temp = 11'h000;
    failures = 0;
    n_tests = 0;
    t = $urandom(32'ha583);
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 16; i++) rd(idx_t[i], rst_t[i]);
    for (i = 0; i < 16; i++) begin
      d = $urandom;
      wr(idx_t[i], d);
      wv[i] = (i inside {0, 1, 2, 4}) ? rst_t[i] : d;
      if (i == 12) wv[i] = d & 16'h3fff;
      if (i == 13) wv[i] = d & 16'h003f;
      if (i == 15) wv[i] = d & 16'hff01;
      rd(idx_t[i], wv[i]);
    end
    chk(trim_word_a, wv[3]);
    wr(`CBST_IDX_BIAS, 16'h0006);
    @(negedge hclk);
    chk(bias_current_control, 6'h06);
    chk(freq_cal_trigger, 1'b0);
    @(posedge hclk);
    wr(`CBST_IDX_CTRL, 16'h0101);
    @(negedge hclk);
    chk(cal_enable, 1'b1);
    chk(freq_cal_trigger, 1'b1);
    chk(hresp, 1'b0);
    @(posedge hclk);
    wr(`CBST_IDX_BIAS, 16'h0001);
    @(negedge hclk);
    chk(bias_current_control, 6'h01);
    chk(freq_cal_trigger, 1'b0);
    @(posedge hclk);
    for (i = 0; i < 6; i++) begin
      wr(idx_t[5 + i], prog_t[i]);
      rd(idx_t[5 + i], prog_t[i]);
    end
    wr(`CBST_IDX_TRIM_H, 16'h2fff);
    rd(`CBST_IDX_TRIM_H, 16'h2fff);
    wr(`CBST_IDX_TRIM_I, 16'h000e);
    rd(`CBST_IDX_TRIM_I, 16'h000e);
    wr(`CBST_IDX_TRIM_J, 16'h0002);
    rd(`CBST_IDX_TRIM_J, 16'h0002);
    wr(`CBST_IDX_IRQ_CLR, 16'h0007);
    wr(`CBST_IDX_IRQ_EN, 16'h0007);
    t = $urandom;
    temp <= t[10:0];
    lock <= 1'b1;
    rd(`CBST_IDX_TEMP, {5'h00, t[10:0]});
    rd(`CBST_IDX_LOCK, 16'h0001);
    rd(`CBST_IDX_IRQ_STAT, 16'h0002);
    @(negedge hclk);
    chk(irq, 1'b1);
    @(posedge hclk);
    wr(`CBST_IDX_IRQ_CLR, 16'h0002);
    lock <= 1'b0;
    wr(`CBST_IDX_IRQ_EN, 16'h0000);
    rd(`CBST_IDX_IRQ_STAT, 16'h0004);
    @(negedge hclk);
    chk(irq, 1'b0);
    @(posedge hclk);
    wr(`CBST_IDX_IRQ_CLR, 16'h0007);
    wr(`CBST_IDX_IRQ_EN, 16'h0001);
    foreach (st_t[s]) begin
      wr(`CBST_IDX_CTRL, {st_t[s], 8'h00});
      pat = $urandom;
      eff = (st_t[s] == 8'h00) ? 1 : st_t[s];
      @(posedge hclk);
      sysref <= 1'b1;
      for (m = 1; m <= 16 * eff; m++) begin
        t = $urandom;
        @(posedge hclk);
        clock_input <= (m % eff == 0) ? pat[m / eff - 1] : t[0];
      end
      repeat (3) @(posedge hclk);
      sysref <= 1'b0;
      rd(`CBST_IDX_SNAP_LO, pat);
      @(negedge hclk);
      chk(irq, 1'b1);
      @(posedge hclk);
      wr(`CBST_IDX_IRQ_CLR, 16'h0001);
    end
    // reset in mid-run brings the trim words back to their reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CBST_IDX_TRIM_B, 16'h78e1);
    rd(`CBST_IDX_TRIM_A, 16'h84a3);
    repeat (2) @(posedge hclk);
    results();
  end
endmodule
